// File: msf_pkg.sv
package msf_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] MSF_OFS_FAN = 8'h22;
   localparam logic [7:0] MSF_OFS_MISC = 8'h23;
   localparam logic [7:0] MSF_OFS_PINS = 8'h24;
   localparam logic [7:0] MSF_RST_VAL = 8'h00;
   // ==========================================================
   // misc flag register bit positions
   localparam int MSF_B_INT_TEMP = 0;
   localparam int MSF_B_BATT = 1;
   localparam int MSF_B_ANALOG_EIGHT = 2;
   localparam int MSF_B_LIMIT_MODE = 3;
   localparam int MSF_B_AUTO_FAN = 4;
   localparam int MSF_B_UNUSED = 5;
   localparam int MSF_B_INTRUDE = 6;
   localparam int MSF_B_PIN16 = 7;
   // ==========================================================
   // pin configuration: each pin owns a bit pair, direction low, polarity high
   localparam int MSF_CFG_DIR_OFS = 0;
   localparam int MSF_CFG_POL_OFS = 1;
   localparam int MSF_PINS_PER_CFG = 4;
   // ==========================================================
   // one-cycle event pulses from the monitor core
   typedef struct packed {
      logic int_limit_on; // on-die thermal limit mode engaged
      logic int_limit_off; // on-die thermal limit mode disengaged
      logic any_limit_on; // any channel engaged thermal limit mode
      logic any_limit_off; // any channel disengaged thermal limit mode
      logic auto_fan_on; // automatic control switched fan on
      logic auto_fan_off; // automatic control switched fan off
      logic intrusion;      // chassis intrusion detected
   } msf_events_type;
   // limit comparison results of the finished conversion
   typedef struct packed {
      logic [7:0] fan_over;  // fan count above high limit, per channel
      logic int_temp_out;    // on-die temperature outside limits
      logic batt_out;        // battery voltage outside limits
      logic analog_eight_out; // analog input eight outside limits
   } msf_limits_type;
endpackage

// File: msf_status_flags.sv
// What this block does
// - fan flag bit n is 1 when channel n count exceeded high limit last conversion
// - misc bit 0 is 1 when on-die temperature was outside limits last conversion
// - misc bit 0 set once when on-die thermal limit mode engages
// - misc bit 0 set once when on-die thermal limit mode disengages
// - misc bits 1 and 2 flag battery and analog input eight out of limits
// - misc bit 3 set once when any channel engages thermal limit mode
// - misc bit 3 set once when thermal limit mode disengages on any channel
// - misc bit 4 set once when automatic control switches the fan on
// - misc bit 4 set once when automatic control switches the fan off
// - misc bit 5 always reads zero
// - misc bit 6 latches a chassis intrusion event
// - misc bit 7 reports asserted state of pin sixteen when it is input
// - writing 1 to misc bit 7 asserts pin sixteen when it is output
// - each pin's asserted level follows its own polarity setting
// - low pin-state bit n reads 1 when input pin n is asserted
// - writing 1 to low pin-state bit n asserts output pin n
// - polarity of pins 0-3 and 4-7 from bits 1,3,5,7 of config one/two
// - all three flag registers are zero after power-on
// - pin state bits are writable only for pins configured as outputs
module msf_status_flags
   import msf_pkg::*;
(
   input wire logic i_clk,                  // 200 MHz system clock
   input wire logic i_rst_n,                // asynchronous reset, active low
   input wire logic i_conv_done,            // pulse: conversion cycle finished
   input wire msf_limits_type i_limits,     // comparison results, valid with i_conv_done
   input wire msf_events_type i_events,     // one-cycle event pulses
   input wire logic [7:0] i_pin_cfg_one,    // pin configuration for pins 0-3
   input wire logic [7:0] i_pin_cfg_two,    // pin configuration for pins 4-7
   input wire logic i_pin16_dir_out,        // pin sixteen configured as output
   input wire logic i_pin16_pol_high,       // pin sixteen active high
   input wire logic [7:0] i_pins,           // level seen on pins 0-7
   input wire logic i_pin16,                // level seen on pin sixteen
   input wire logic [7:0] i_addr,           // register offset
   input wire logic i_wr,                   // write strobe
   input wire logic [7:0] i_wdata,          // write data
   input wire logic i_rd,                   // read strobe
   output logic [7:0] o_rdata,              // read data, one cycle after i_rd
   output logic [7:0] o_pins,               // drive level for pins 0-7
   output logic [7:0] o_pins_oe,            // drive enable for pins 0-7
   output logic o_pin16,                    // drive level for pin sixteen
   output logic o_pin16_oe                  // drive enable for pin sixteen
);
   // ==========================================================
   // helpers
   // asserted means the pin sits at its polarity level
   function automatic logic asserted(input logic lvl, input logic pol_high);
      asserted = (lvl == pol_high);
   endfunction

   // pick direction or polarity bits of the two configuration bytes
   function automatic logic [7:0] cfg_bits(input logic [7:0] c1, input logic [7:0] c2,
                                           input int ofs);
      logic [7:0] r;
      r = 8'h00;
      for (int n = 0; n < MSF_PINS_PER_CFG; n++) begin
         r[n] = c1[2*n+ofs];
         r[n+MSF_PINS_PER_CFG] = c2[2*n+ofs];
      end
      cfg_bits = r;
   endfunction

   // ==========================================================
   // reset release
   logic rst_meta_q;
   logic rst_n;

   // release through two flops so the core never sees a ragged release
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // ==========================================================
   // flag state
   logic [7:0] fan_q, fan_d;
   logic int_lvl_q, int_lvl_d;
   logic batt_q, batt_d;
   logic analog_eight_q, analog_eight_d;
   logic int_ev_q, int_ev_d;
   logic lim_mode_q, lim_mode_d;
   logic auto_fan_q, auto_fan_d;
   logic intr_q, intr_d;
   logic pin16_q, pin16_d;
   logic [7:0] pins_q, pins_d;
   logic [7:0] rdata_q, rdata_d;
   logic [7:0] dir_out;
   logic [7:0] pol_high;
   logic [7:0] misc_val;
   logic rd_misc;
   logic wr_misc;
   logic wr_pins;

   assign dir_out = cfg_bits(i_pin_cfg_one, i_pin_cfg_two, MSF_CFG_DIR_OFS);
   assign pol_high = cfg_bits(i_pin_cfg_one, i_pin_cfg_two, MSF_CFG_POL_OFS);
   assign rd_misc = i_rd && (i_addr == MSF_OFS_MISC);
   assign wr_misc = i_wr && (i_addr == MSF_OFS_MISC);
   assign wr_pins = i_wr && (i_addr == MSF_OFS_PINS);

   // misc register image; bit 5 has no storage
   always_comb begin
      misc_val = MSF_RST_VAL;
      misc_val[MSF_B_INT_TEMP] = int_lvl_q | int_ev_q;
      misc_val[MSF_B_BATT] = batt_q;
      misc_val[MSF_B_ANALOG_EIGHT] = analog_eight_q;
      misc_val[MSF_B_LIMIT_MODE] = lim_mode_q;
      misc_val[MSF_B_AUTO_FAN] = auto_fan_q;
      misc_val[MSF_B_UNUSED] = 1'b0;
      misc_val[MSF_B_INTRUDE] = intr_q;
      misc_val[MSF_B_PIN16] = pin16_q;
   end

   // next values: limit levels follow each conversion, events stick until read
   always_comb begin
      fan_d = fan_q;
      int_lvl_d = int_lvl_q;
      batt_d = batt_q;
      analog_eight_d = analog_eight_q;
      if (i_conv_done) begin
         fan_d = i_limits.fan_over;
         int_lvl_d = i_limits.int_temp_out;
         batt_d = i_limits.batt_out;
         analog_eight_d = i_limits.analog_eight_out;
      end
      // a read clears the events, but an event in the same cycle wins
      int_ev_d = (int_ev_q && !rd_misc) || i_events.int_limit_on
                 || i_events.int_limit_off;
      lim_mode_d = (lim_mode_q && !rd_misc) || i_events.any_limit_on
                   || i_events.any_limit_off;
      auto_fan_d = (auto_fan_q && !rd_misc) || i_events.auto_fan_on
                   || i_events.auto_fan_off;
      intr_d = (intr_q && !rd_misc) || i_events.intrusion;
      // pin sixteen: input samples the pin, output holds the written value
      if (!i_pin16_dir_out) begin
         pin16_d = asserted(i_pin16, i_pin16_pol_high);
      end else if (wr_misc) begin
         pin16_d = i_wdata[MSF_B_PIN16];
      end else begin
         pin16_d = pin16_q;
      end
      // pins 0-7: writes land only on output pins
      for (int n = 0; n < 8; n++) begin
         if (!dir_out[n]) begin
            pins_d[n] = asserted(i_pins[n], pol_high[n]);
         end else if (wr_pins) begin
            pins_d[n] = i_wdata[n];
         end else begin
            pins_d[n] = pins_q[n];
         end
      end
      // read data
      rdata_d = rdata_q;
      if (i_rd) begin
         case (i_addr)
            MSF_OFS_FAN: rdata_d = fan_q;
            MSF_OFS_MISC: rdata_d = misc_val;
            MSF_OFS_PINS: rdata_d = pins_q;
            default: rdata_d = MSF_RST_VAL;
         endcase
      end
   end

   // all flags come up zero
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         fan_q <= MSF_RST_VAL;
         int_lvl_q <= 1'b0;
         batt_q <= 1'b0;
         analog_eight_q <= 1'b0;
         int_ev_q <= 1'b0;
         lim_mode_q <= 1'b0;
         auto_fan_q <= 1'b0;
         intr_q <= 1'b0;
         pin16_q <= 1'b0;
         pins_q <= MSF_RST_VAL;
         rdata_q <= MSF_RST_VAL;
      end else begin
         fan_q <= fan_d;
         int_lvl_q <= int_lvl_d;
         batt_q <= batt_d;
         analog_eight_q <= analog_eight_d;
         int_ev_q <= int_ev_d;
         lim_mode_q <= lim_mode_d;
         auto_fan_q <= auto_fan_d;
         intr_q <= intr_d;
         pin16_q <= pin16_d;
         pins_q <= pins_d;
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // outputs
   // drive level maps the stored assert bit through the polarity
   assign o_rdata = rdata_q;
   assign o_pins = ~(pins_q ^ pol_high);
   assign o_pins_oe = dir_out;
   assign o_pin16 = (pin16_q == i_pin16_pol_high);
   assign o_pin16_oe = i_pin16_dir_out;

   // ==========================================================
   // checks
   property p_fan_update;
      @(posedge i_clk) disable iff (!rst_n)
      i_conv_done |=> fan_q == $past(i_limits.fan_over);
   endproperty
   a_fan_update: assert property (p_fan_update) else $error("fan flags not refreshed");

   property p_fan_hold;
      @(posedge i_clk) disable iff (!rst_n)
      !i_conv_done ##1 !i_conv_done |=> $stable(fan_q);
   endproperty
   a_fan_hold: assert property (p_fan_hold) else $error("fan flags moved");

   property p_int_level;
      @(posedge i_clk) disable iff (!rst_n)
      i_conv_done && i_limits.int_temp_out ##1 i_rd && i_addr == MSF_OFS_MISC
      |=> o_rdata[MSF_B_INT_TEMP];
   endproperty
   a_int_level: assert property (p_int_level) else $error("temp flag missing");

   property p_int_event;
      @(posedge i_clk) disable iff (!rst_n)
      (i_events.int_limit_on || i_events.int_limit_off) |=> int_ev_q;
   endproperty
   a_int_event: assert property (p_int_event) else $error("temp event lost");

   property p_int_off;
      @(posedge i_clk) disable iff (!rst_n)
      i_events.int_limit_off |=> int_ev_q;
   endproperty
   a_int_off: assert property (p_int_off) else $error("temp release lost");

   property p_mode_event;
      @(posedge i_clk) disable iff (!rst_n)
      (i_events.any_limit_on || i_events.any_limit_off) ##1 i_rd && i_addr == MSF_OFS_MISC
      |=> o_rdata[MSF_B_LIMIT_MODE];
   endproperty
   a_mode_event: assert property (p_mode_event) else $error("thermal event lost");

   property p_mode_off;
      @(posedge i_clk) disable iff (!rst_n)
      i_events.any_limit_off |=> lim_mode_q;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("thermal release lost");

   property p_fan_event;
      @(posedge i_clk) disable iff (!rst_n)
      (i_events.auto_fan_on || i_events.auto_fan_off) |=> auto_fan_q;
   endproperty
   a_fan_event: assert property (p_fan_event) else $error("fan event lost");

   property p_fan_off;
      @(posedge i_clk) disable iff (!rst_n)
      i_events.auto_fan_off |=> auto_fan_q;
   endproperty
   a_fan_off: assert property (p_fan_off) else $error("fan stop event lost");

   property p_clear_on_read;
      @(posedge i_clk) disable iff (!rst_n)
      rd_misc && !i_events.intrusion |=> !intr_q;
   endproperty
   a_clear_on_read: assert property (p_clear_on_read) else $error("intrusion not cleared");

   property p_unused_zero;
      @(posedge i_clk) disable iff (!rst_n)
      i_rd && i_addr == MSF_OFS_MISC |=> !o_rdata[MSF_B_UNUSED];
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

   property p_pin_input;
      @(posedge i_clk) disable iff (!rst_n)
      1'b1 |=> ((pins_q ^ ~($past(i_pins) ^ $past(pol_high))) & ~$past(dir_out)) == 8'h00;
   endproperty
   a_pin_input: assert property (p_pin_input) else $error("input pin state wrong");

   property p_pin_write;
      @(posedge i_clk) disable iff (!rst_n)
      wr_pins |=> ((pins_q ^ $past(i_wdata)) & $past(dir_out)) == 8'h00;
   endproperty
   a_pin_write: assert property (p_pin_write) else $error("output pin write lost");

   property p_pin16_drive;
      @(posedge i_clk) disable iff (!rst_n)
      i_pin16_dir_out && wr_misc ##1 i_pin16_dir_out && !wr_misc
      |-> o_pin16 == ($past(i_wdata[MSF_B_PIN16]) == i_pin16_pol_high);
   endproperty
   a_pin16_drive: assert property (p_pin16_drive) else $error("pin sixteen drive wrong");

   property p_pin16_input;
      @(posedge i_clk) disable iff (!rst_n)
      !i_pin16_dir_out |=> pin16_q == ($past(i_pin16) == $past(i_pin16_pol_high));
   endproperty
   a_pin16_input: assert property (p_pin16_input) else $error("pin16 input wrong");

   // voltage levels follow the conversion just like the fan flags
   property p_volt_update;
      @(posedge i_clk) disable iff (!rst_n)
      i_conv_done |=> batt_q == $past(i_limits.batt_out)
                      && analog_eight_q == $past(i_limits.analog_eight_out);
   endproperty
   a_volt_update: assert property (p_volt_update) else $error("voltage flags stale");

   // only a read may drop a latched intrusion
   property p_intrusion_hold;
      @(posedge i_clk) disable iff (!rst_n)
      intr_q && !rd_misc |=> intr_q;
   endproperty
   a_intrusion_hold: assert property (p_intrusion_hold) else $error("intrusion lost");
endmodule

// File: msf_status_flags_tb_top.sv
module msf_status_flags_tb_top
   import msf_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // stimulus and observation
   logic i_clk, i_rst_n, i_conv_done, i_pin16_dir_out, i_pin16_pol_high, i_pin16, i_wr, i_rd;
   msf_limits_type i_limits;
   msf_events_type i_events;
   logic [7:0] i_pin_cfg_one, i_pin_cfg_two, i_pins, i_addr, i_wdata, o_rdata, o_pins, o_pins_oe;
   logic o_pin16, o_pin16_oe;
   logic [7:0] rv;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   msf_status_flags u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_conv_done(i_conv_done),
      .i_limits(i_limits), .i_events(i_events), .i_pin_cfg_one(i_pin_cfg_one),
      .i_pin_cfg_two(i_pin_cfg_two), .i_pin16_dir_out(i_pin16_dir_out),
      .i_pin16_pol_high(i_pin16_pol_high), .i_pins(i_pins), .i_pin16(i_pin16),
      .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_pins(o_pins), .o_pins_oe(o_pins_oe), .o_pin16(o_pin16), .o_pin16_oe(o_pin16_oe));
   // ==========================================================
   // clock and hang guard, ceiling far above the roughly 120 cycles needed
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count = bad_count + 1;
         test_done();
      end
   end
   // ==========================================================
   // shared helpers; every driver change lands 1 ns after the edge
   task automatic step();
      @(posedge i_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      step();
      i_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      i_addr = a;
      i_rd = 1'b1;
      step();
      i_rd = 1'b0;
      d = o_rdata;
      step(); // idle cycle so a following read raises a fresh strobe
   endtask
   task automatic conv(input logic [7:0] fan, input logic [2:0] lv);
      i_limits = {fan, lv};
      i_conv_done = 1'b1;
      step();
      i_conv_done = 1'b0;
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      rd(MSF_OFS_FAN, rv); chk(rv, 8'h00, "fan reset");
      rd(MSF_OFS_MISC, rv); chk(rv, 8'h00, "misc reset");
      rd(MSF_OFS_PINS, rv); chk(rv, 8'h00, "pins reset");
      $display("test reset done");
   endtask
   task automatic t_limits();
      conv(8'h81, 3'b101);
      rd(MSF_OFS_MISC, rv); chk(rv, 8'h05, "misc levels");
      wr(MSF_OFS_FAN, 8'hff);
      rd(MSF_OFS_FAN, rv); chk(rv, 8'h81, "fan flags");
      conv(8'h7e, 3'b010);
      rd(MSF_OFS_FAN, rv); chk(rv, 8'h7e, "fan refresh");
      rd(MSF_OFS_MISC, rv); chk(rv, 8'h02, "misc refresh");
      conv(8'h00, 3'b000);
      $display("test limits done");
   endtask
   task automatic t_events();
      int bitpos[7] = '{0, 0, 3, 3, 4, 4, 6};
      for (int i = 0; i < 7; i++) begin
         i_events = 7'(1 << (6 - i));
         step();
         i_events = '0;
         repeat (3) step();
         rd(MSF_OFS_MISC, rv); chk(rv, 8'(1 << bitpos[i]), "event set");
         rd(MSF_OFS_MISC, rv); chk(rv, 8'h00, "event cleared by read");
      end
      // thermal event read at once, then intrusion inside a clearing read
      i_events = 7'h10;
      step();
      i_events = 7'h01;
      i_addr = MSF_OFS_MISC;
      i_rd = 1'b1;
      step();
      i_events = '0;
      i_rd = 1'b0;
      chk(o_rdata, 8'h08, "event read at once");
      step();
      rd(MSF_OFS_MISC, rv);
      chk(rv, 8'h40, "event beats clear");
      rd(MSF_OFS_MISC, rv);
      chk(rv, 8'h00, "intrusion cleared by read");
      $display("test events done");
   endtask
   task automatic t_pins_in();
      logic [7:0] pats[3] = '{8'h00, 8'hff, 8'h5a};
      i_pin_cfg_one = 8'h22;
      i_pin_cfg_two = 8'h88;
      foreach (pats[i]) begin
         i_pins = pats[i];
         repeat (2) step();
         rd(MSF_OFS_PINS, rv); chk(rv, ~(pats[i] ^ 8'ha5), "input pin state");
         chk(o_pins_oe, 8'h00, "inputs undriven");
      end
      $display("test input pins done");
   endtask
   task automatic t_pins_out();
      // low nibble outputs, pin one active high; high nibble active-low inputs
      i_pin_cfg_one = 8'h5d;
      i_pin_cfg_two = 8'h00;
      i_pins = 8'h30;
      wr(MSF_OFS_PINS, 8'ha5);
      step();
      chk(o_pins_oe, 8'h0f, "output enables");
      chk({4'h0, o_pins[3:0]}, 8'h08, "output levels");
      rd(MSF_OFS_PINS, rv); chk(rv, 8'hc5, "write only on outputs");
      $display("test output pins done");
   endtask
   task automatic t_pin16();
      i_pin16_pol_high = 1'b0;
      repeat (2) step();
      rd(MSF_OFS_MISC, rv); chk(rv, 8'h80, "pin16 input asserted");
      i_pin16_pol_high = 1'b1;
      repeat (2) step();
      rd(MSF_OFS_MISC, rv); chk(rv, 8'h00, "pin16 input idle");
      i_pin16_dir_out = 1'b1;
      i_pin16_pol_high = 1'b0;
      wr(MSF_OFS_MISC, 8'hff);
      step();
      chk({6'h0, o_pin16_oe, o_pin16}, 8'h02, "pin16 driven asserted");
      rd(MSF_OFS_MISC, rv); chk(rv, 8'h80, "misc write only bit 7");
      wr(MSF_OFS_MISC, 8'h00);
      step();
      chk({6'h0, o_pin16_oe, o_pin16}, 8'h03, "pin16 driven idle");
      $display("test pin16 done");
   endtask
   // ==========================================================
   // main sequence
   initial begin
      i_rst_n = 1'b0;
      {i_conv_done, i_wr, i_rd, i_pin16_dir_out, i_pin16} = '0;
      i_pin16_pol_high = 1'b1;
      i_limits = '0;
      i_events = '0;
      i_pin_cfg_one = 8'haa;
      i_pin_cfg_two = 8'haa;
      i_pins = 8'h00;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      repeat (5) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      repeat (3) step();
      t_reset();
      t_limits();
      t_events();
      t_pins_in();
      t_pins_out();
      t_pin16();
      test_done();
   end
endmodule
